/* rtl/l4_key_pkg.sv */
// Purpose: Constants shared by the layer 3/4 and OAM key field builder
// Assumes: Classic Wishbone register access, 32-bit data, byte addresses
// Notes: Range types are plain codes held in the type registers
package l4_key_pkg;
    // Protocol and EtherType values
    localparam logic [7:0] PROTO_TCP = 8'h06;
    localparam logic [7:0] PROTO_UDP = 8'h11;
    localparam logic [15:0] ETHERTYPE_KEY_FIELD_OAM = 16'h8902;
    localparam logic [31:0] SEQ_ZERO = 32'h0000_0000;

    // Payload byte offsets from the start of the IP header
    localparam int V4_PAYLOAD_OFS = 20;
    localparam int V6_PAYLOAD_OFS = 40;
    localparam int L3_WIN_BYTES = 52;

    // Range checker count
    localparam int RNG_COUNT = 16;

    // TCP control flag positions
    localparam int TF_FIN = 0;
    localparam int TF_SYN = 1;
    localparam int TF_RST = 2;
    localparam int TF_PSH = 3;
    localparam int TF_ACK = 4;
    localparam int TF_URG = 5;

    // Range checker type encodings
    localparam logic [2:0] RNG_OFF = 3'h0;
    localparam logic [2:0] RNG_SPORT = 3'h1;
    localparam logic [2:0] RNG_DPORT = 3'h2;
    localparam logic [2:0] RNG_EITHER = 3'h3;
    localparam logic [2:0] RNG_VID = 3'h4;
    localparam logic [2:0] RNG_DSCP = 3'h5;
    localparam logic [2:0] RNG_CUSTOM = 3'h6;

    // Register map, byte addresses
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_FRAMES = 8'h04;
    localparam logic [7:0] REG_RNG_BASE = 8'h40;
    localparam logic [7:0] REG_RNG_END = 8'hC0;
    localparam logic [7:0] REG_RNG_BOUNDS = 8'h04;

    // Status register bit positions
    localparam int ST_MASK_LSB = 0;
    localparam int ST_TRANSPORT = 16;
    localparam int ST_STREAM = 17;
    localparam int ST_OAM = 18;
    localparam int ST_LCZ = 19;

    // Values after reset
    localparam logic [2:0] RST_RNG_TYPE = 3'h0;
    localparam logic [15:0] RST_RNG_MIN = 16'h0000;
    localparam logic [15:0] RST_RNG_MAX = 16'hFFFF;
    localparam logic [31:0] RST_FRAMES = 32'h0000_0000;
endpackage : l4_key_pkg

/* rtl/range_checker.sv */
// Purpose: One range checker of the range match mask
// Assumes: Inclusive bounds, min not above max
// Notes: Purely combinational, no state
module range_checker (
    input wire logic [2:0] i_type,
    input wire logic [15:0] i_min,
    input wire logic [15:0] i_max,
    input wire logic i_ports_ok,
    input wire logic [15:0] i_sport,
    input wire logic [15:0] i_dport,
    input wire logic [11:0] i_vid,
    input wire logic [5:0] i_dscp,
    input wire logic [15:0] i_custom,
    output logic o_hit
);
    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction : in_range

    always_comb begin
        case (i_type)
            l4_key_pkg::RNG_SPORT: o_hit = i_ports_ok && in_range(i_sport, i_min, i_max);
            l4_key_pkg::RNG_DPORT: o_hit = i_ports_ok && in_range(i_dport, i_min, i_max);
            l4_key_pkg::RNG_EITHER: o_hit = i_ports_ok && (in_range(i_sport, i_min, i_max)
                                                          || in_range(i_dport, i_min, i_max));
            l4_key_pkg::RNG_VID: o_hit = in_range({4'h0, i_vid}, i_min, i_max);
            l4_key_pkg::RNG_DSCP: o_hit = in_range({10'h000, i_dscp}, i_min, i_max);
            l4_key_pkg::RNG_CUSTOM: o_hit = in_range(i_custom, i_min, i_max);
            default: o_hit = 1'b0;
        endcase
    end
endmodule : range_checker

/* rtl/l4_key_fields.sv */
// Purpose: Builds the layer 3/4 and OAM key fields for the egress content lookup
// Assumes: Parser presents one frame per i_frm_valid cycle on the core clock
// Notes: Key fields appear one cycle after i_frm_valid with a one-cycle o_key_valid
// Overview of operation
// - The protocol field is the IPv4 protocol or IPv6 next header, chosen by v4.
// - The transport flag is set for IP frames with protocol 6 or 17, else cleared.
// - The stream-protocol flag is set when the IP protocol or next header is 6.
// - In the seven-tuple key a non-TRANSPORT_KNOWN_FLAG IP frame carries its protocol as dest port.
// - The ports-equal flag is set when source port equals destination port.
// - Sixteen checkers on sport, dport, either, VID, DSCP or custom form a mask.
// - VID and DSCP checkers use classified values, port and custom ones frame contents.
// - The zero-sequence flag is set when the TCP sequence number is 0.
// - 96 payload bits after the IP header are taken, IPv4 always 20 bytes in.
// - 64 bits after the TRANSPORT_KNOWN_FLAG header fill the transport payload field.
// - Seven-tuple non-transport frames get the first 8 bytes after the IP header instead.
// - The loss-counters-zero flag is set when TxFCf, RxFCb and TxFCb are all zero.
// - EtherType 0x8902 sets the OAM flag and the EtherType field then holds MEL flags.
//
// Local design decisions: the Wishbone register port and the register offsets.
module l4_key_fields (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // Parsed frame
    input wire logic i_frm_valid,
    input wire logic i_is_ip,
    input wire logic i_v4_indicator,
    input wire logic [7:0] i_ip_protocol,
    input wire logic [7:0] i_next_header,
    input wire logic [15:0] i_ethertype,
    input wire logic [2:0] i_oam_mel,
    input wire logic [15:0] i_src_port,
    input wire logic [15:0] i_dst_port,
    input wire logic [5:0] i_tcp_flags,
    input wire logic [31:0] i_tcp_seqnum,
    input wire logic [415:0] i_l3_window,
    input wire logic [63:0] i_transport_payload_bytes,
    input wire logic [31:0] i_ccm_txfcf,
    input wire logic [31:0] i_ccm_rxfcb,
    input wire logic [31:0] i_ccm_txfcb,
    input wire logic [15:0] i_custom_value,
    input wire logic [11:0] i_class_vid,
    input wire logic [5:0] i_class_dscp,
    // Key fields
    output logic o_key_valid,
    output logic [7:0] o_network_protocol_field,
    output logic o_transport_known_flag,
    output logic o_stream_proto_flag,
    output logic [15:0] o_transport_dest_port,
    output logic [15:0] o_transport_src_port,
    output logic [15:0] o_seven_tuple_dest_port,
    output logic [15:0] o_range_match_mask,
    output logic o_ports_equal_flag,
    output logic o_zero_seqnum_flag,
    output logic [5:0] o_tcp_ctrl_flags,
    output logic [95:0] o_network_payload_bytes,
    output logic [63:0] o_transport_payload_bytes,
    output logic [63:0] o_seven_tuple_payload_bytes,
    output logic o_loss_counters_zero_flag,
    output logic o_oam_ethertype_flag,
    output logic [15:0] o_ethertype_key_field
);
    localparam int WIN_W = l4_key_pkg::L3_WIN_BYTES * 8;
    localparam int V4_TOP = WIN_W - 1 - 8 * l4_key_pkg::V4_PAYLOAD_OFS;
    localparam int V6_TOP = WIN_W - 1 - 8 * l4_key_pkg::V6_PAYLOAD_OFS;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

    typedef struct packed {
        bus_state_t bus;
        logic [31:0] rdat;
        logic [15:0][2:0] rtype;
        logic [15:0][15:0] rmin;
        logic [15:0][15:0] rmax;
        logic [31:0] frames;
        logic kvalid;
        logic [7:0] proto;
        logic transport;
        logic stream;
        logic [15:0] dport;
        logic [15:0] sport;
        logic [15:0] st_dport;
        logic [15:0] mask;
        logic peq;
        logic zseq;
        logic [5:0] tflags;
        logic [95:0] l3pl;
        logic [63:0] l4pl;
        logic [63:0] st_l4pl;
        logic lcz;
        logic oam;
        logic [15:0] ethertype_key_field;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [15:0] rng_hit;
    logic [7:0] proto_sel;
    logic transport_now;
    logic [95:0] l3_now;

    // Protocol choice of the key build
    function automatic logic [7:0] sel_proto(input logic v4, input logic [7:0] p4,
                                             input logic [7:0] nh);
        sel_proto = v4 ? p4 : nh;
    endfunction : sel_proto

    function automatic logic in_rng_space(input logic [7:0] adr);
        in_rng_space = (adr >= l4_key_pkg::REG_RNG_BASE) && (adr < l4_key_pkg::REG_RNG_END);
    endfunction : in_rng_space

    function automatic logic [3:0] rng_index(input logic [7:0] adr);
        logic [7:0] rel;
        rel = adr - l4_key_pkg::REG_RNG_BASE;
        rng_index = rel[6:3];
    endfunction : rng_index

    function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        byte_merge = (old & ~m) | (nw & m);
    endfunction : byte_merge

    // Port checkers only see meaningful ports on TRANSPORT_KNOWN_FLAG frames
    generate
        for (genvar g = 0; g < l4_key_pkg::RNG_COUNT; g++) begin : g_rng
            range_checker u_chk (
                .i_type(s_q.rtype[g]),
                .i_min(s_q.rmin[g]),
                .i_max(s_q.rmax[g]),
                .i_ports_ok(transport_now),
                .i_sport(i_src_port),
                .i_dport(i_dst_port),
                .i_vid(i_class_vid),
                .i_dscp(i_class_dscp),
                .i_custom(i_custom_value),
                .o_hit(rng_hit[g])
            );
        end
    endgenerate

    assign proto_sel = sel_proto(i_v4_indicator, i_ip_protocol, i_next_header);
    assign transport_now = i_is_ip && ((proto_sel == l4_key_pkg::PROTO_TCP)
                                       || (proto_sel == l4_key_pkg::PROTO_UDP));
    // Options are never parsed, so the IPv4 offset is fixed
    assign l3_now = i_v4_indicator ? i_l3_window[V4_TOP -: 96]
                                   : i_l3_window[V6_TOP -: 96];

    always_comb begin
        logic [31:0] old_w;
        logic [3:0] idx;
        s_d = s_q;
        old_w = 32'h0000_0000;
        idx = rng_index(i_wb_adr);
        s_d.kvalid = i_frm_valid;
        // A request is answered in the next cycle, then ack drops
        case (s_q.bus)
            BUS_IDLE: begin
                if (i_wb_cyc && i_wb_stb) begin
                    s_d.bus = BUS_ACK;
                    s_d.rdat = 32'h0000_0000;
                    if (i_wb_adr == l4_key_pkg::REG_STATUS) begin
                        s_d.rdat[l4_key_pkg::ST_MASK_LSB +: 16] = s_q.mask;
                        s_d.rdat[l4_key_pkg::ST_TRANSPORT] = s_q.transport;
                        s_d.rdat[l4_key_pkg::ST_STREAM] = s_q.stream;
                        s_d.rdat[l4_key_pkg::ST_OAM] = s_q.oam;
                        s_d.rdat[l4_key_pkg::ST_LCZ] = s_q.lcz;
                    end else if (i_wb_adr == l4_key_pkg::REG_FRAMES) begin
                        s_d.rdat = s_q.frames;
                    end else if (in_rng_space(i_wb_adr) && !i_wb_adr[2]) begin
                        old_w = {29'h0000_0000, s_q.rtype[idx]};
                        s_d.rdat = old_w;
                        if (i_wb_we) begin
                            old_w = byte_merge(old_w, i_wb_dat, i_wb_sel);
                            s_d.rtype[idx] = old_w[2:0];
                        end
                    end else if (in_rng_space(i_wb_adr)) begin
                        old_w = {s_q.rmax[idx], s_q.rmin[idx]};
                        s_d.rdat = old_w;
                        if (i_wb_we) begin
                            old_w = byte_merge(old_w, i_wb_dat, i_wb_sel);
                            s_d.rmax[idx] = old_w[31:16];
                            s_d.rmin[idx] = old_w[15:0];
                        end
                    end
                end
            end
            BUS_ACK: begin
                s_d.bus = BUS_IDLE;
            end
            default: begin
                s_d.bus = BUS_IDLE;
            end
        endcase
        // Key build: all fields register together so the lookup sees one frame
        if (i_frm_valid) begin
            s_d.frames = s_q.frames + 32'h0000_0001;
            s_d.proto = proto_sel;
            s_d.transport = transport_now;
            s_d.stream = i_is_ip && (proto_sel == l4_key_pkg::PROTO_TCP);
            s_d.dport = i_dst_port;
            s_d.sport = i_src_port;
            s_d.st_dport = (i_is_ip && !transport_now) ? {8'h00, proto_sel}
                                                       : i_dst_port;
            s_d.peq = (i_src_port == i_dst_port);
            s_d.mask = rng_hit;
            s_d.zseq = i_is_ip && (proto_sel == l4_key_pkg::PROTO_TCP)
                       && (i_tcp_seqnum == l4_key_pkg::SEQ_ZERO);
            s_d.tflags = i_tcp_flags;
            s_d.l3pl = l3_now;
            s_d.l4pl = i_transport_payload_bytes;
            s_d.st_l4pl = transport_now ? i_transport_payload_bytes : l3_now[95:32];
            s_d.lcz = (i_ccm_txfcf == 32'h0000_0000) && (i_ccm_rxfcb == 32'h0000_0000)
                      && (i_ccm_txfcb == 32'h0000_0000);
            s_d.oam = (i_ethertype == l4_key_pkg::ETHERTYPE_KEY_FIELD_OAM);
            s_d.ethertype_key_field = (i_ethertype == l4_key_pkg::ETHERTYPE_KEY_FIELD_OAM)
                        ? {8'h00, 8'(8'h01 << i_oam_mel)} : i_ethertype;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_q <= '0;
            s_q.bus <= BUS_IDLE;
            s_q.frames <= l4_key_pkg::RST_FRAMES;
            for (int k = 0; k < l4_key_pkg::RNG_COUNT; k++) begin
                s_q.rtype[k] <= l4_key_pkg::RST_RNG_TYPE;
                s_q.rmin[k] <= l4_key_pkg::RST_RNG_MIN;
                s_q.rmax[k] <= l4_key_pkg::RST_RNG_MAX;
            end
        end else begin
            s_q <= s_d;
        end
    end

    assign o_wb_ack = (s_q.bus == BUS_ACK);
    assign o_wb_dat = s_q.rdat;
    assign o_key_valid = s_q.kvalid;
    assign o_network_protocol_field = s_q.proto;
    assign o_transport_known_flag = s_q.transport;
    assign o_stream_proto_flag = s_q.stream;
    assign o_transport_dest_port = s_q.dport;
    assign o_transport_src_port = s_q.sport;
    assign o_seven_tuple_dest_port = s_q.st_dport;
    assign o_range_match_mask = s_q.mask;
    assign o_ports_equal_flag = s_q.peq;
    assign o_zero_seqnum_flag = s_q.zseq;
    assign o_tcp_ctrl_flags = s_q.tflags;
    assign o_network_payload_bytes = s_q.l3pl;
    assign o_transport_payload_bytes = s_q.l4pl;
    assign o_seven_tuple_payload_bytes = s_q.st_l4pl;
    assign o_loss_counters_zero_flag = s_q.lcz;
    assign o_oam_ethertype_flag = s_q.oam;
    assign o_ethertype_key_field = s_q.ethertype_key_field;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);

    property p_proto;
        i_frm_valid |=> o_network_protocol_field
                        == ($past(i_v4_indicator) ? $past(i_ip_protocol) : $past(i_next_header));
    endproperty
    a_proto: assert property (p_proto) else $error("protocol field wrong");

    property p_transport;
        i_frm_valid && i_is_ip && ((i_ip_protocol == 8'h11 && i_v4_indicator)
                                   || (i_next_header == 8'h06 && !i_v4_indicator))
            |=> o_transport_known_flag && o_key_valid;
    endproperty
    a_transport: assert property (p_transport) else $error("transport flag missing");

    property p_stream;
        o_key_valid |-> o_stream_proto_flag
                        == (o_transport_known_flag && o_network_protocol_field == 8'h06);
    endproperty
    a_stream: assert property (p_stream) else $error("stream flag wrong");

    property p_st_dport;
        o_key_valid && !o_transport_known_flag && $past(i_is_ip)
            |-> o_seven_tuple_dest_port == {8'h00, o_network_protocol_field};
    endproperty
    a_st_dport: assert property (p_st_dport) else $error("dest port overload wrong");

    property p_peq;
        o_key_valid |-> o_ports_equal_flag == (o_transport_src_port == o_transport_dest_port);
    endproperty
    a_peq: assert property (p_peq) else $error("ports equal flag wrong");

    property p_zseq;
        o_zero_seqnum_flag && o_key_valid |-> o_stream_proto_flag && $past(i_tcp_seqnum) == 0;
    endproperty
    a_zseq: assert property (p_zseq) else $error("zero sequence flag wrong");

    property p_l3pl;
        i_frm_valid && i_v4_indicator
            |=> o_network_payload_bytes == $past(i_l3_window[255:160]);
    endproperty
    a_l3pl: assert property (p_l3pl) else $error("IPv4 payload offset wrong");

    property p_st_pl;
        o_key_valid && !o_transport_known_flag
            |-> o_seven_tuple_payload_bytes == o_network_payload_bytes[95:32];
    endproperty
    a_st_pl: assert property (p_st_pl) else $error("seven tuple payload wrong");

    property p_oam;
        o_key_valid && o_oam_ethertype_flag |-> o_ethertype_key_field[15:8] == 8'h00
                                               && $onehot(o_ethertype_key_field[7:0]);
    endproperty
    a_oam: assert property (p_oam) else $error("OAM EtherType overload wrong");

    property p_ack;
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack timing wrong");

    c_tcp: cover property (o_key_valid && o_stream_proto_flag && o_zero_seqnum_flag);
    c_other_ip: cover property (o_key_valid && !o_transport_known_flag);
    c_oam: cover property (o_key_valid && o_oam_ethertype_flag && o_loss_counters_zero_flag);
    c_rng: cover property (o_key_valid && o_range_match_mask != 16'h0000);
endmodule : l4_key_fields

/* sim/key_sink.sv */
// Purpose: Stand-in for the lookup engine taking each key
// Assumes: One key per o_key_valid pulse, fields settled in that cycle
// Notes: Only counts keys; matching is outside this block
module key_sink (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_key_valid,
    input wire logic i_transport,
    output logic [15:0] o_keys,
    output logic [15:0] o_tr_keys
);
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_keys <= 16'h0000;
            o_tr_keys <= 16'h0000;
        end else if (i_key_valid) begin
            o_keys <= o_keys + 16'h0001;
            o_tr_keys <= o_tr_keys + {15'h0000, i_transport};
        end
    end
endmodule : key_sink

/* sim/test_l4_key_fields.sv */
// Purpose: Self-checking bench of the key field builder
// Assumes: Registered outputs, read before the edge updates them
// Notes: Driver queues expectations; monitor pops and compares
module test_l4_key_fields;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] proto;
        logic tr, st, peq, zs, lz, oam, ip;
        logic [15:0] dp, sp, dp7, mask, et;
        logic [5:0] tf;
        logic [95:0] l3p;
        logic [63:0] l4p, p7;
    } key_t;
    logic i_ref_clk = 1'b0, i_resetn = 1'b0;
    logic i_wb_cyc, i_wb_stb, i_wb_we, i_frm_valid, i_is_ip, i_v4_indicator;
    logic [7:0] i_wb_adr, i_ip_protocol, i_next_header, o_network_protocol_field;
    logic [3:0] i_wb_sel;
    logic [31:0] i_wb_dat, o_wb_dat, i_tcp_seqnum, i_ccm_txfcf, i_ccm_rxfcb, i_ccm_txfcb;
    logic o_wb_ack, o_key_valid, o_transport_known_flag, o_stream_proto_flag;
    logic o_ports_equal_flag, o_zero_seqnum_flag, o_loss_counters_zero_flag, o_oam_ethertype_flag;
    logic [15:0] i_ethertype, i_src_port, i_dst_port, i_custom_value, o_transport_dest_port;
    logic [15:0] o_transport_src_port, o_seven_tuple_dest_port, o_range_match_mask;
    logic [15:0] o_ethertype_key_field, keys, tr_keys;
    logic [2:0] i_oam_mel;
    logic [5:0] i_tcp_flags, i_class_dscp, o_tcp_ctrl_flags;
    logic [415:0] i_l3_window;
    logic [63:0] i_transport_payload_bytes, o_transport_payload_bytes, o_seven_tuple_payload_bytes;
    logic [95:0] o_network_payload_bytes;
    logic [11:0] i_class_vid;
    logic [2:0] typ [16];
    key_t kq [$];
    logic [31:0] rdq [$];
    key_t e, last;
    int seed = 98;
    int num_errors = 0, n_compared = 0, n_frames = 0, n_tr = 0;

    l4_key_fields dut_u (.i_ref_clk, .i_resetn, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
        .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_frm_valid, .i_is_ip, .i_v4_indicator,
        .i_ip_protocol, .i_next_header, .i_ethertype, .i_oam_mel, .i_src_port, .i_dst_port,
        .i_tcp_flags, .i_tcp_seqnum, .i_l3_window, .i_transport_payload_bytes, .i_ccm_txfcf, .i_ccm_rxfcb,
        .i_ccm_txfcb, .i_custom_value, .i_class_vid, .i_class_dscp, .o_key_valid,
        .o_network_protocol_field, .o_transport_known_flag, .o_stream_proto_flag,
        .o_transport_dest_port, .o_transport_src_port, .o_seven_tuple_dest_port,
        .o_range_match_mask, .o_ports_equal_flag, .o_zero_seqnum_flag, .o_tcp_ctrl_flags,
        .o_network_payload_bytes, .o_transport_payload_bytes, .o_seven_tuple_payload_bytes,
        .o_loss_counters_zero_flag, .o_oam_ethertype_flag, .o_ethertype_key_field);
    key_sink sink_u (.i_ref_clk, .i_resetn, .i_key_valid(o_key_valid),
        .i_transport(o_transport_known_flag), .o_keys(keys), .o_tr_keys(tr_keys));

    always #5 i_ref_clk = ~i_ref_clk;

    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run

    // Hold the request until ack is seen at an edge, then idle one cycle
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      input logic [31:0] exp);
        int n;
        if (!we) rdq.push_back(exp);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_adr <= adr;
        i_wb_dat <= dat;
        n = 0;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            complete_run();
        end
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        @(posedge i_ref_clk);
    endtask : wb

    function automatic logic inr(input logic [15:0] v);
        return v >= 16'h0010 && v <= 16'h0030;
    endfunction : inr

    task automatic send_frame();
        key_t k;
        logic [2:0] kind, mel;
        logic [31:0] z, seq, tx, rx, tb;
        logic [7:0] ob;
        logic [415:0] w;
        logic [15:0] cu;
        logic [11:0] vid;
        logic [5:0] ds;
        logic v4, h;
        logic [7:0] ptab [4] = '{8'h06, 8'h11, 8'h01, 8'h3A};
        kind = 3'($random(seed));
        z = $random(seed);
        k.ip = kind[2:1] != 2'b11;
        v4 = kind[0];
        k.proto = ptab[2'($random(seed))];
        ob = 8'($random(seed));
        k.et = k.ip ? (v4 ? 16'h0800 : 16'h86DD)
                    : (v4 ? l4_key_pkg::ETHERTYPE_KEY_FIELD_OAM : 16'($random(seed)));
        mel = 3'($random(seed));
        k.sp = 16'($random(seed)) & 16'h003F;
        k.dp = z[0] ? k.sp : 16'($random(seed)) & 16'h003F;
        seq = z[1] ? 32'h0000_0000 : $random(seed);
        tx = (z[2] && k.et == l4_key_pkg::ETHERTYPE_KEY_FIELD_OAM) ? 32'h0000_0000 : $random(seed) | 32'h1;
        rx = (z[2] || z[3]) ? 32'h0000_0000 : $random(seed);
        tb = (z[2] || z[3]) ? 32'h0000_0000 : $random(seed);
        for (int j = 0; j < 13; j++) w[j*32 +: 32] = $random(seed);
        k.l4p = {$random(seed), $random(seed)};
        k.tf = 6'($random(seed));
        cu = 16'($random(seed)) & 16'h003F;
        vid = 12'($random(seed)) & 12'h03F;
        ds = 6'($random(seed));
        i_frm_valid <= 1'b1;
        i_is_ip <= k.ip;
        i_v4_indicator <= v4;
        i_ip_protocol <= v4 ? k.proto : ob;
        i_next_header <= v4 ? ob : k.proto;
        i_ethertype <= k.et;
        i_oam_mel <= mel;
        i_src_port <= k.sp;
        i_dst_port <= k.dp;
        i_tcp_flags <= k.tf;
        i_tcp_seqnum <= seq;
        i_l3_window <= w;
        i_transport_payload_bytes <= k.l4p;
        i_ccm_txfcf <= tx;
        i_ccm_rxfcb <= rx;
        i_ccm_txfcb <= tb;
        i_custom_value <= cu;
        i_class_vid <= vid;
        i_class_dscp <= ds;
        k.tr = k.ip && (k.proto == l4_key_pkg::PROTO_TCP || k.proto == l4_key_pkg::PROTO_UDP);
        k.st = k.ip && k.proto == l4_key_pkg::PROTO_TCP;
        k.dp7 = (k.ip && !k.tr) ? {8'h00, k.proto} : k.dp;
        k.peq = k.sp == k.dp;
        k.zs = k.st && seq == 32'h0000_0000;
        k.lz = tx == 32'h0000_0000 && rx == 32'h0000_0000 && tb == 32'h0000_0000;
        k.oam = k.et == l4_key_pkg::ETHERTYPE_KEY_FIELD_OAM;
        if (k.oam) k.et = {8'h00, 8'h01 << mel};
        k.l3p = v4 ? w[255:160] : w[95:0];
        k.p7 = k.tr ? k.l4p : (v4 ? w[255:192] : w[95:32]);
        for (int i = 0; i < 16; i++) begin
            case (typ[i])
                3'h1: h = k.tr && inr(k.sp);
                3'h2: h = k.tr && inr(k.dp);
                3'h3: h = k.tr && (inr(k.sp) || inr(k.dp));
                3'h4: h = inr({4'h0, vid});
                3'h5: h = inr({10'h000, ds});
                3'h6: h = inr(cu);
                default: h = 1'b0;
            endcase
            k.mask[i] = h;
        end
        kq.push_back(k);
        last = k;
        n_frames++;
        n_tr += k.tr;
        @(posedge i_ref_clk);
    endtask : send_frame

    always @(posedge i_ref_clk) begin
        if (o_wb_ack === 1'b1 && i_wb_we === 1'b0) begin
            if (rdq.size() == 0) check("unexpected ack", 1'b1, 1'b0);
            else check("read data", o_wb_dat, rdq.pop_front());
        end
        if (o_key_valid === 1'b1) begin
            if (kq.size() == 0) check("unexpected key", 1'b1, 1'b0);
            else begin
                e = kq.pop_front();
                check("protocol", o_network_protocol_field, e.proto);
                check("transport flag", o_transport_known_flag, e.tr);
                check("stream flag", o_stream_proto_flag, e.st);
                check("seven tuple dport", o_seven_tuple_dest_port, e.dp7);
                check("ports", {o_transport_src_port, o_transport_dest_port}, {e.sp, e.dp});
                check("ports equal", o_ports_equal_flag, e.peq);
                check("range mask", o_range_match_mask, e.mask);
                check("zero seq", o_zero_seqnum_flag, e.zs);
                if (e.ip) check("network_payload_bytes", o_network_payload_bytes, e.l3p);
                check("transport_payload_bytes", o_transport_payload_bytes, e.l4p);
                check("seven tuple payload", o_seven_tuple_payload_bytes, e.p7);
                check("loss zero", o_loss_counters_zero_flag, e.lz);
                check("oam flag", o_oam_ethertype_flag, e.oam);
                check("ethertype_key_field field", o_ethertype_key_field, e.et);
                check("tcp flags", o_tcp_ctrl_flags, e.tf);
            end
        end
    end

    initial begin
        {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_frm_valid} = '0;
        i_wb_sel = 4'hF;
        repeat (5) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        @(posedge i_ref_clk);
        wb(1'b0, l4_key_pkg::REG_FRAMES, 32'h0, 32'h0000_0000);
        wb(1'b0, 8'hB8, 32'h0, 32'h0000_0000);
        wb(1'b0, 8'hBC, 32'h0, 32'hFFFF_0000);
        i_wb_sel <= 4'h3;
        wb(1'b1, 8'hBC, 32'h1234_5678, 32'h0);
        i_wb_sel <= 4'hF;
        wb(1'b0, 8'hBC, 32'h0, 32'hFFFF_5678);
        wb(1'b1, 8'h08, 32'h1234_5678, 32'h0);
        wb(1'b0, 8'h08, 32'h0, 32'h0000_0000);
        // Checkers 0..6 get type codes 1..7; the rest stay off
        for (int i = 0; i < 16; i++) begin
            typ[i] = (i < 7) ? 3'(i + 1) : 3'h0;
            wb(1'b1, 8'(8'h40 + 8 * i), {29'h0, typ[i]}, 32'h0);
            wb(1'b1, 8'(8'h44 + 8 * i), 32'h0030_0010, 32'h0);
        end
        wb(1'b0, 8'h40 + 8'h08, 32'h0, 32'h0000_0002);
        for (int f = 0; f < 300; f++) send_frame();
        i_frm_valid <= 1'b0;
        for (int n = 0; n < 20 && kq.size() > 0; n++) @(posedge i_ref_clk);
        check("keys drained", kq.size(), 0);
        wb(1'b0, l4_key_pkg::REG_STATUS, 32'h0,
           {12'h000, last.lz, last.oam, last.st, last.tr, last.mask});
        wb(1'b0, l4_key_pkg::REG_FRAMES, 32'h0, 32'(n_frames));
        check("sink keys", {keys, tr_keys}, {16'(n_frames), 16'(n_tr)});
        complete_run();
    end
endmodule : test_l4_key_fields
